/* inc/eewr_pkg.sv */
/*
 Shared constants and types of the two-wire memory write slave.
 Assumes a 10 MHz system clock and a bus master that drives the serial clock.
*/
// Contract
// - Device is only a slave; the master alone makes the clock and directs traffic.
// - START is SDA falling while SCL high; nothing is answered before one.
// - STOP is SDA rising while SCL high; it completes any command.
// - Bits are sampled on SCL rise; device output changes on SCL fall, open drain.
// - After START take eight address bits; answer only type 1010 and matching select pins.
// - Last address bit chooses direction: one reads, zero writes.
// - Variant without select pins answers only when select bits are all zero.
// - Unconnected select and write-protect pins read as low.
// - In the ninth clock the receiver pulls SDA low to acknowledge, else leaves it.
// - In a write the device acknowledges every byte the master sends, except data bytes while write protect is high.
// - STOP after a write starts programming up to 4 ms; no acknowledge meanwhile.
// - Up to 32 data bytes per write enter the page buffer from the given address.
// - Page part stays fixed; in-page offset increments and wraps to page start.
// - After STOP all loaded bytes go to the array in one programming cycle.
// - With write protect high nothing is written to the array.
// - Reset holds the device; commands are accepted within 0.35 ms after it ends.
// - Pulses up to 50 ns on SCL and SDA are suppressed.
// - Write protect is sampled before the first data byte; high rejects and refuses it.
package eewr_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int GLITCH_NS = 50;
	localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INTERNAL_PROGRAM_TIME_MS = 4;
	localparam int PROG_CYC = INTERNAL_PROGRAM_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam real POWERUP_READY_DELAY_MS = 0.35;
	localparam int POWERUP_CYC = int'($floor(POWERUP_READY_DELAY_MS * 1.0E6 / CLK_PERIOD_NS));
	localparam int MEM_AW = 13;
	localparam int PAGE_BYTES = 32;
	localparam int OFS_W = 5;
	localparam int PAGE_W = MEM_AW - OFS_W;
	localparam int DIR_BIT = 0;
	localparam int SEL_LSB = 1;
	localparam int SEL_MSB = 3;
	localparam int TYPE_LSB = 4;
	localparam logic [3:0] DEV_TYPE = 4'hA;
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	typedef enum logic [3:0] {ST_IDLE, ST_DEV, ST_ACK_DEV, ST_AHI, ST_ACK_AHI, ST_ALO, ST_ACK_ALO,
		ST_DATA, ST_ACK_DATA, ST_IGNORE} eewr_state_t;
endpackage : eewr_pkg

/* inc/eewr_tmr_if.sv */
/*
 Start and status signals of one delay timer.
 Assumes the user raises start for one cycle while the timer is idle.
*/
interface eewr_tmr_if;
	logic start;
	logic busy;
	logic done;
	modport timer (input start, output busy, output done);
	modport user (output start, input busy, input done);
endinterface : eewr_tmr_if

/* logic/eewr_timer.sv */
/*
 One-shot delay timer: busy for exactly CYC cycles after a start.
 Assumes start comes from logic on the same clock.
*/
module eewr_timer
	import eewr_pkg::*;
#(
	parameter int CYC = 4
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	eewr_tmr_if.timer tmr
);
	localparam int CW = $clog2(CYC + 1);
	logic [CW-1:0] cnt_reg;
	logic busy_reg;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
		end
		else if (!busy_reg && tmr.start)
		begin
			cnt_reg <= CW'(CYC - 1);
			busy_reg <= 1'b1;
		end
		else if (busy_reg)
		begin
			if (cnt_reg == '0)
				busy_reg <= 1'b0;
			else
				cnt_reg <= cnt_reg - 1'b1;
		end
	end

	assign tmr.busy = busy_reg;
	assign tmr.done = busy_reg && (cnt_reg == '0);
endmodule : eewr_timer

/* logic/eewr_pin_filter.sv */
/*
 Two-stage synchroniser and glitch filter for a group of pins.
 Assumes inputs are asynchronous to the system clock.
*/
module eewr_pin_filter
	import eewr_pkg::*;
#(
	parameter int W = 2,
	parameter int STABLE = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_lvl
);
	localparam int CW = $clog2(STABLE + 1) + 1;
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] lvl_reg;
	logic [CW-1:0] cnt_reg [W];

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end
		else
		begin
			meta_reg <= i_pin;
			sync_reg <= meta_reg;
		end
	end

	// A new level is taken only after it was seen on STABLE + 1 samples in a row.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			lvl_reg <= RST_VAL;
			for (int i = 0; i < W; i++)
				cnt_reg[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < W; i++)
			begin
				if (sync_reg[i] == lvl_reg[i])
					cnt_reg[i] <= '0;
				else if (cnt_reg[i] == CW'(STABLE))
				begin
					lvl_reg[i] <= sync_reg[i];
					cnt_reg[i] <= '0;
				end
				else
					cnt_reg[i] <= cnt_reg[i] + 1'b1;
			end
		end
	end

	assign o_lvl = lvl_reg;

	a_glitch_reject:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(lvl_reg != $past(lvl_reg)) |->
		((($past(sync_reg, 1) ^ lvl_reg) | ($past(sync_reg, 2) ^ lvl_reg)) & (lvl_reg ^ $past(lvl_reg))) == '0)
		else $error("Filtered level changed without a stable input.");
endmodule : eewr_pin_filter

/* logic/eewr_write_slave.sv */
/*
 Write side of a two-wire byte-addressed nonvolatile memory slave: start and stop
 detection, address match, acknowledge, page buffer, programming and power-up delay.
 Assumes SCL comes from an external master; SDA is open drain, resolved outside.
*/
module eewr_write_slave
	import eewr_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC,
	parameter bit NO_SEL_PINS = 1'b0
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	input wire logic i_addr_select_bit0_pin,
	input wire logic i_addr_select_bit1_pin,
	input wire logic i_addr_select_bit2_pin,
	input wire logic i_wp,
	input wire logic [MEM_AW-1:0] i_peek_addr,
	output logic [7:0] o_peek_data,
	output logic o_ready,
	output logic o_prog_busy
);
	logic [1:0] bus_lvl;
	logic [3:0] strap_lvl;
	logic scl;
	logic sda;
	logic scl_q_reg;
	logic sda_q_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	eewr_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shreg_reg;
	logic sda_oe_n_reg;
	logic [2:0] sel_exp;
	logic byte_end;
	logic ack_ok;
	logic [7:0] addr_hi_reg;
	logic [MEM_AW-1:0] full_addr;
	logic [PAGE_W-1:0] page_reg;
	logic [OFS_W-1:0] ofs_reg;
	logic [7:0] pbuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pvalid_reg;
	logic loaded_reg;
	logic wp_lat_reg;
	logic store_byte;
	logic pu_done_reg;
	logic [31:0] prog_len_reg;
	// The array leaves the factory erased; the value is set at declaration so only one process writes it.
	logic [7:0] mem [2**MEM_AW] = '{default: ERASED_BYTE};
	eewr_tmr_if prog_if ();
	eewr_tmr_if pu_if ();

	// Bus lines idle high; strap pins are pulled low outside when unconnected.
	eewr_pin_filter #(
		.W(2),
		.STABLE(GLITCH_CYC),
		.RST_VAL(2'h3)
	) u_bus_filter (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_pin({i_scl, i_sda}),
		.o_lvl(bus_lvl)
	);

	eewr_pin_filter #(
		.W(4),
		.STABLE(GLITCH_CYC),
		.RST_VAL(4'h0)
	) u_strap_filter (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_pin({i_wp, i_addr_select_bit2_pin, i_addr_select_bit1_pin, i_addr_select_bit0_pin}),
		.o_lvl(strap_lvl)
	);

	eewr_timer #(
		.CYC(PROG_CYCLES)
	) u_prog_timer (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.tmr(prog_if)
	);

	eewr_timer #(
		.CYC(POWERUP_CYC)
	) u_pu_timer (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.tmr(pu_if)
	);

	assign scl = bus_lvl[1];
	assign sda = bus_lvl[0];

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end
		else
		begin
			scl_q_reg <= scl;
			sda_q_reg <= sda;
		end
	end

	assign scl_rise = scl && !scl_q_reg;
	assign scl_fall = !scl && scl_q_reg;
	// SDA moving while SCL stays high can only be a START or STOP from the master.
	assign start_det = scl && scl_q_reg && sda_q_reg && !sda;
	assign stop_det = scl && scl_q_reg && !sda_q_reg && sda;

	assign sel_exp = NO_SEL_PINS ? SEL_NONE : strap_lvl[2:0];
	assign byte_end = scl_fall && (bit_cnt_reg == BIT_LAST);

	always_comb
	begin
		case (state_reg)
			ST_DEV:
				ack_ok = (shreg_reg[7:TYPE_LSB] == DEV_TYPE) && (shreg_reg[SEL_MSB:SEL_LSB] == sel_exp)
					&& pu_done_reg && !prog_if.busy;
			ST_AHI, ST_ALO:
				ack_ok = 1'b1;
			ST_DATA:
				ack_ok = !wp_lat_reg;
			default:
				ack_ok = 1'b0;
		endcase
	end

	// Protocol sequencer: bits in on SCL rise, acknowledge driven and released on SCL fall.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= '0;
			shreg_reg <= '0;
			sda_oe_n_reg <= 1'b1;
		end
		else if (start_det)
		begin
			state_reg <= ST_DEV;
			bit_cnt_reg <= '0;
			sda_oe_n_reg <= 1'b1;
		end
		else if (stop_det)
		begin
			state_reg <= ST_IDLE;
			sda_oe_n_reg <= 1'b1;
		end
		else
		begin
			case (state_reg)
				ST_DEV, ST_AHI, ST_ALO, ST_DATA:
				begin
					if (scl_rise && bit_cnt_reg != BIT_LAST)
					begin
						shreg_reg <= {shreg_reg[6:0], sda};
						bit_cnt_reg <= bit_cnt_reg + 1'b1;
					end
					else if (byte_end)
					begin
						bit_cnt_reg <= '0;
						if (ack_ok)
						begin
							sda_oe_n_reg <= 1'b0;
							case (state_reg)
								ST_DEV:
									state_reg <= ST_ACK_DEV;
								ST_AHI:
									state_reg <= ST_ACK_AHI;
								ST_ALO:
									state_reg <= ST_ACK_ALO;
								default:
									state_reg <= ST_ACK_DATA;
							endcase
						end
						else
							state_reg <= ST_IGNORE;
					end
				end
				ST_ACK_DEV, ST_ACK_AHI, ST_ACK_ALO, ST_ACK_DATA:
				begin
					if (scl_fall)
					begin
						sda_oe_n_reg <= 1'b1;
						case (state_reg)
							ST_ACK_DEV:
								state_reg <= shreg_reg[DIR_BIT] ? ST_IGNORE : ST_AHI;
							ST_ACK_AHI:
								state_reg <= ST_ALO;
							ST_ACK_ALO:
								state_reg <= ST_DATA;
							default:
								state_reg <= ST_DATA;
						endcase
					end
				end
				default:
					state_reg <= state_reg;
			endcase
		end
	end

	assign full_addr = MEM_AW'({addr_hi_reg, shreg_reg});
	assign store_byte = (state_reg == ST_DATA) && byte_end && !wp_lat_reg && !start_det && !stop_det;

	// Page buffer: page fixed at the address, offset wraps inside the page.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			addr_hi_reg <= '0;
			page_reg <= '0;
			ofs_reg <= '0;
			pvalid_reg <= '0;
			loaded_reg <= 1'b0;
			wp_lat_reg <= 1'b0;
		end
		else if (start_det || stop_det)
			loaded_reg <= 1'b0;
		else if (scl_fall && state_reg == ST_ACK_AHI)
			addr_hi_reg <= shreg_reg;
		else if (scl_fall && state_reg == ST_ACK_ALO)
		begin
			page_reg <= full_addr[MEM_AW-1:OFS_W];
			ofs_reg <= full_addr[OFS_W-1:0];
			pvalid_reg <= '0;
			wp_lat_reg <= strap_lvl[3];
		end
		else if (store_byte)
		begin
			pbuf[ofs_reg] <= shreg_reg;
			pvalid_reg[ofs_reg] <= 1'b1;
			ofs_reg <= ofs_reg + 1'b1;
			loaded_reg <= 1'b1;
		end
	end

	// Programming starts only when a STOP ends a session with accepted data.
	assign prog_if.start = stop_det && loaded_reg && !wp_lat_reg;

	always_ff @(posedge i_clk_sys)
	begin
		if (prog_if.done && !wp_lat_reg)
		begin
			for (int i = 0; i < PAGE_BYTES; i++)
				if (pvalid_reg[i])
					mem[{page_reg, OFS_W'(i)}] <= pbuf[i];
		end
		o_peek_data <= mem[i_peek_addr];
	end

	// Power-up delay runs once after every reset before commands are answered.
	assign pu_if.start = !pu_done_reg && !pu_if.busy;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			pu_done_reg <= 1'b0;
		else if (pu_if.done)
			pu_done_reg <= 1'b1;
	end

	assign o_ready = pu_done_reg;
	assign o_prog_busy = prog_if.busy;
	// Only SDA is ever pulled low; SCL is never driven by this slave.
	assign o_sda = 1'b0;
	assign o_sda_oe_n = sda_oe_n_reg;

	// Counts programming cycles so that the length of the busy window can be checked.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst || !prog_if.busy)
			prog_len_reg <= '0;
		else
			prog_len_reg <= prog_len_reg + 1'b1;
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	a_idle_released:
	assert property ((state_reg == ST_IDLE || state_reg == ST_IGNORE) |-> sda_oe_n_reg)
		else $error("SDA driven while idle or ignoring.");
	a_start_enters:
	assert property (start_det |=> state_reg == ST_DEV && bit_cnt_reg == '0)
		else $error("START did not begin address reception.");
	a_stop_idles:
	assert property (stop_det |=> state_reg == ST_IDLE && sda_oe_n_reg && !loaded_reg)
		else $error("STOP did not end the command.");
	a_drive_on_fall:
	assert property ($fell(sda_oe_n_reg) |-> $past(scl_fall) && $past(bit_cnt_reg) == BIT_LAST)
		else $error("Acknowledge not started on the eighth bit fall.");
	a_ack_addr_match:
	assert property ($fell(sda_oe_n_reg) && $past(state_reg) == ST_DEV |->
		$past(shreg_reg[7:TYPE_LSB]) == DEV_TYPE && $past(shreg_reg[SEL_MSB:SEL_LSB]) == $past(sel_exp))
		else $error("Acknowledged a foreign slave address.");
	a_busy_silent:
	assert property ((prog_if.busy || !pu_done_reg) |-> sda_oe_n_reg)
		else $error("Acknowledge while programming or powering up.");
	a_stop_programs:
	assert property (stop_det && loaded_reg && !wp_lat_reg |=> prog_if.busy ##1 prog_if.busy)
		else $error("STOP after data did not start programming.");
	a_no_empty_prog:
	assert property ($rose(prog_if.busy) |-> $past(loaded_reg) && !$past(wp_lat_reg) && $past(stop_det))
		else $error("Programming started without accepted data.");
	a_offset_wrap:
	assert property (store_byte |=> ofs_reg == $past(ofs_reg) + 1'b1 && page_reg == $past(page_reg))
		else $error("In-page offset did not step within the page.");
	a_wp_nack:
	assert property (state_reg == ST_DATA && byte_end && wp_lat_reg && !stop_det |=>
		sda_oe_n_reg && state_reg == ST_IGNORE)
		else $error("Protected data byte was acknowledged.");
	a_write_acked:
	assert property (byte_end && (state_reg == ST_AHI || state_reg == ST_ALO) && !stop_det |=> !sda_oe_n_reg)
		else $error("Memory address byte not acknowledged.");
	a_ack_release:
	assert property (!sda_oe_n_reg && scl_fall |=> sda_oe_n_reg)
		else $error("Acknowledge held past the ninth clock.");
	a_read_ignored:
	assert property (state_reg == ST_ACK_DEV && scl_fall && shreg_reg[DIR_BIT] |=>
		state_reg == ST_IGNORE && sda_oe_n_reg)
		else $error("Read request was not left to the next START.");
	a_wp_no_commit:
	assert property (prog_if.done |-> !wp_lat_reg)
		else $error("Array committed while write protect was latched.");
	a_prog_length:
	assert property ($fell(prog_if.busy) |-> prog_len_reg == 32'(PROG_CYCLES))
		else $error("Programming window length differs from the set cycles.");

	c_page_commit: cover property (prog_if.done && !wp_lat_reg && (&pvalid_reg));
	c_wp_reject: cover property (state_reg == ST_DATA && byte_end && wp_lat_reg);
	c_offset_wrap: cover property (store_byte && ofs_reg == '1);
	c_poll_nack: cover property (state_reg == ST_DEV && byte_end && prog_if.busy);
	c_read_request: cover property (state_reg == ST_ACK_DEV && scl_fall && shreg_reg[DIR_BIT]);
endmodule : eewr_write_slave

/* tb/eewr_i2c_master.sv */
/*
 Behavioural two-wire bus master that drives the serial clock for the write slave.
 Assumes the bench resolves SDA with a pull-up and runs a 10 MHz system clock.
*/
module eewr_i2c_master
(
	input wire logic i_clk_sys,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_scl = 1'b1;
		o_sda_oe_n = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask : wt
	// Called only from an idle bus, both lines high.
	task automatic start();
		o_scl <= 1'b1;
		wt(4);
		o_sda_oe_n <= 1'b0;
		wt(4);
	endtask : start
	task automatic stop();
		o_scl <= 1'b0;
		wt(2);
		o_sda_oe_n <= 1'b0;
		wt(2);
		o_scl <= 1'b1;
		wt(4);
		o_sda_oe_n <= 1'b1;
		wt(6);
	endtask : stop
	// SDA changes only while SCL is low; one clock is 800 ns.
	// SCL stays low for five cycles so that a slave releasing its acknowledge after the filtered
	// fall has reached the filtered data line before the rise, which avoids a false STOP or START.
	task automatic clk_bit(input logic v, output logic s);
		o_scl <= 1'b0;
		wt(1);
		o_sda_oe_n <= v;
		wt(4);
		o_scl <= 1'b1;
		wt(2);
		s = i_sda;
		wt(1);
	endtask : clk_bit
	task automatic put(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], s);
		// Released in the ninth clock so the slave can answer.
		clk_bit(1'b1, s);
		ack = (s === 1'b0);
	endtask : put
endmodule : eewr_i2c_master

/* tb/eewr_write_slave_tb.sv */
/*
 Self-checking bench of the two-wire memory write slave with a bus master model.
 Assumes SDA has a pull-up and the programming time is shortened by parameter.
*/
module eewr_write_slave_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import eewr_pkg::*;
	localparam int PROG = 200;
	logic clk_sys, rst, scl, sda, m_oe_n, wp, sda_oe_n, sda_drv, ready, busy, ack0;
	logic [2:0] sel;
	logic [MEM_AW-1:0] peek_addr, a;
	logic [7:0] peek_data;
	logic [7:0] mem [0:(1<<MEM_AW)-1];
	logic [7:0] dat [0:39];
	logic [7:0] masks [4] = '{8'h80, 8'h08, 8'h04, 8'h02};
	int miscompares = 0, compares = 0, cyc = 0, rel_cyc, busy_tot = 0, d, n;
	// Open drain with pull-up: the slave only wins when it is enabled and drives a low level.
	assign sda = (!m_oe_n || (!sda_oe_n && sda_drv === 1'b0)) ? 1'b0 : 1'b1;
	eewr_write_slave #(.PROG_CYCLES(PROG), .NO_SEL_PINS(1'b0)) u_eewr_write_slave (.i_clk_sys(clk_sys),
		.i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda(sda_drv), .o_sda_oe_n(sda_oe_n),
		.i_addr_select_bit0_pin(sel[0]), .i_addr_select_bit1_pin(sel[1]), .i_addr_select_bit2_pin(sel[2]),
		.i_wp(wp), .i_peek_addr(peek_addr), .o_peek_data(peek_data), .o_ready(ready), .o_prog_busy(busy));
	eewr_i2c_master u_eewr_i2c_master (.i_clk_sys(clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(m_oe_n));
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (busy === 1'b1)
			busy_tot <= busy_tot + 1;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("Counts: %0d compares, %0d miscompares", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	function automatic logic [7:0] dev_byte(input logic rd);
		return {DEV_TYPE, sel, rd};
	endfunction : dev_byte
	task automatic peek_page(input logic [MEM_AW-1:0] pa);
		for (int i = 0; i < PAGE_BYTES; i++)
		begin
			@(posedge clk_sys);
			peek_addr <= {pa[MEM_AW-1:OFS_W], i[OFS_W-1:0]};
			repeat (2) @(posedge clk_sys);
			chk("page byte", peek_data, mem[{pa[MEM_AW-1:OFS_W], i[OFS_W-1:0]}]);
		end
	endtask : peek_page
	// Sends one write session and checks acknowledges, programming length and array contents.
	task automatic txn(input logic [7:0] dev, input logic [MEM_AW-1:0] ta, input int cnt, input int exp_acks,
		input bit prog);
		logic ack;
		int acks, bt0, polls;
		bt0 = busy_tot;
		acks = 0;
		for (int i = 0; i < 40; i++)
			dat[i] = 8'($urandom());
		u_eewr_i2c_master.start();
		u_eewr_i2c_master.put(dev, ack);
		acks += int'(ack);
		if (ack)
		begin
			u_eewr_i2c_master.put({3'h0, ta[MEM_AW-1:8]}, ack);
			acks += int'(ack);
		end
		if (ack)
		begin
			u_eewr_i2c_master.put(ta[7:0], ack);
			acks += int'(ack);
		end
		for (int i = 0; i < cnt && ack; i++)
		begin
			u_eewr_i2c_master.put(dat[i], ack);
			acks += int'(ack);
		end
		u_eewr_i2c_master.stop();
		chk("acks", acks, exp_acks);
		if (prog)
		begin
			polls = 0;
			// Repeats the address until the slave answers again.
			do
			begin
				u_eewr_i2c_master.start();
				u_eewr_i2c_master.put(dev, ack);
				u_eewr_i2c_master.stop();
				if (polls == 0)
					chk("poll while busy", ack, 1'b0);
				polls++;
			end
			while (!ack && polls < 20);
			for (int i = 0; i < cnt; i++)
				mem[{ta[MEM_AW-1:OFS_W], ta[OFS_W-1:0] + i[OFS_W-1:0]}] = dat[i];
		end
		repeat (5) @(posedge clk_sys);
		chk("busy cycles", busy_tot - bt0, prog ? PROG : 0);
		peek_page(ta);
	endtask : txn
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		rst = 1'b1;
		wp = 1'b0;
		peek_addr = '0;
		void'($urandom(78073));
		sel = 3'($urandom());
		for (int i = 0; i < (1 << MEM_AW); i++)
			mem[i] = ERASED_BYTE;
		repeat (5) @(posedge clk_sys);
		chk("ready in reset", ready, 1'b0);
		chk("sda in reset", sda_oe_n, 1'b1);
		rst <= 1'b0;
		rel_cyc = cyc;
		txn(dev_byte(1'b0), '0, 1, 0, 0);
		for (int i = 0; i < 5000 && ready !== 1'b1; i++)
			@(posedge clk_sys);
		d = cyc - rel_cyc;
		chk("ready delay", (d >= POWERUP_CYC && d <= POWERUP_CYC + 2), 1'b1);
		$display("Test reset done");
		u_eewr_i2c_master.put(dev_byte(1'b0), ack0);
		chk("byte without start", ack0, 1'b0);
		txn(dev_byte(1'b0), MEM_AW'($urandom()), 1, 4, 1);
		$display("Test byte write done");
		txn(dev_byte(1'b0), {PAGE_W'($urandom()), 5'h1E}, 34, 37, 1);
		$display("Test page wrap done");
		a = MEM_AW'($urandom());
		for (int k = 0; k < 4; k++)
			txn(dev_byte(1'b0) ^ masks[k], a, 1, 0, 0);
		txn(dev_byte(1'b1), a, 1, 1, 0);
		txn(dev_byte(1'b0), a, 0, 3, 0);
		$display("Test refusals done");
		@(posedge clk_sys);
		wp <= 1'b1;
		txn(dev_byte(1'b0), a, 2, 3, 0);
		wp <= 1'b0;
		$display("Test write protect done");
		repeat (3)
		begin
			n = 1 + ($urandom() % PAGE_BYTES);
			txn(dev_byte(1'b0), MEM_AW'($urandom()), n, 3 + n, 1);
		end
		$display("Test random writes done");
		tally_and_finish();
	end
endmodule : eewr_write_slave_tb
